// [verilog/vrs_pkg.sv]
// constants for the virtual-mode roller / ball-screw output axis
// assumes one 100 MHz clock and an operation-cycle tick from the drive side
package vrs_pkg;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_GEAR    = 8'h08;
  localparam logic [7:0] OFS_RATIO   = 8'h0C;
  localparam logic [7:0] OFS_DROOP   = 8'h10;
  localparam logic [7:0] OFS_SPDLIM  = 8'h14;
  localparam logic [7:0] OFS_STRKUP  = 8'h18;
  localparam logic [7:0] OFS_STRKLO  = 8'h1C;
  localparam logic [7:0] OFS_TRQSRC  = 8'h20;
  localparam logic [7:0] OFS_GEOM    = 8'h24;
  localparam logic [7:0] OFS_PPREV   = 8'h28;
  localparam logic [7:0] OFS_DEVADDR = 8'h2C;
  localparam logic [7:0] OFS_DEVDATA = 8'h30;
  localparam logic [7:0] OFS_POS     = 8'h34;
  localparam logic [7:0] OFS_CMDSPD  = 8'h38;
  localparam logic [7:0] OFS_TRAVPP  = 8'h3C;
  localparam logic [7:0] OFS_TORQUE  = 8'h40;
  // control bits
  localparam int CB_VIRT = 0;
  localparam int CB_SCREW = 1;
  localparam int CB_UNIT = 2;
  localparam int CB_REALUNIT = 3;
  localparam int CB_CLUTCH = 4;
  localparam int CB_TRQASN = 5;
  localparam int CB_BACKLASH = 6;
  // status bits
  localparam int SB_ERR = 0;
  localparam int SB_MODEERR = 1;
  localparam int SB_DROOP = 2;
  localparam int SB_SPEED = 3;
  localparam int SB_STROKE = 4;
  // reset values
  localparam logic [31:0] RST_DROOP  = 32'd6553500;
  localparam logic [31:0] RST_GEAR   = 32'h0001_0000;
  localparam logic [15:0] TRQ_DEFAULT = 16'd300;
  localparam int          FRAC_BITS  = 16;
  // device areas and index limits
  localparam logic [1:0]  AREA_D = 2'd0;
  localparam logic [1:0]  AREA_W = 2'd1;
  localparam logic [1:0]  AREA_M = 2'd2;
  localparam logic [1:0]  AREA_U = 2'd3;
  localparam logic [13:0] LIM_D = 14'd8191;
  localparam logic [13:0] LIM_W = 14'h1FFF;
  localparam logic [13:0] LIM_M = 14'd7999;
  localparam logic [13:0] RSV_LO = 14'd800;
  localparam logic [13:0] RSV_HI = 14'd1559;
  // roller monitor: 60 * pi / 100 with pi as 355/113
  localparam logic [31:0] MON_NUM = 32'd21300;
  localparam logic [31:0] MON_DEN = 32'd11300;
  localparam logic [1:0]  BUS_WAIT = 2'd2;
endpackage

// [verilog/vrs_dev_mem.sv]
// word store for the user device areas (data, link, motion, shared)
// assumes one writer and one reader port, read data registered
`timescale 1ns/1ps
module vrs_dev_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // no reset on the array; read register only
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule

// [verilog/vrs_axis.sv]
// virtual-mode roller / ball-screw output axis with avalon-mm registers
// assumes drive speed/travel arrive with opTick, deviation from the servo
`timescale 1ns/1ps
module vrs_axis #(
  parameter int DEV_AW = 8
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        opTick,
  input  wire logic [31:0] driveSpeed,
  input  wire logic [31:0] driveTravel,
  input  wire logic        clutchOn,
  input  wire logic [31:0] deviation,
  output logic      [31:0] cmdSpeed,
  output logic      [31:0] cmdTravel,
  output logic      [15:0] torqueLimit,
  output logic             backlashEn,
  output logic             axis_error_detect_flag
);
  import vrs_pkg::*;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic devValid(input logic [15:0] a);
    unique case (a[15:14])
      AREA_D: devValid = a[13:0] <= LIM_D;
      AREA_W: devValid = a[13:0] <= LIM_W;
      AREA_M: devValid = a[13:0] <= LIM_M;
      AREA_U: devValid = 1'b1;
    endcase
  endfunction

  function automatic logic devReserved(input logic [15:0] a);
    devReserved = a[15:14] == AREA_D && a[13:0] >= RSV_LO
                  && a[13:0] <= RSV_HI;
  endfunction

  function automatic logic [DEV_AW-1:0] devIdx(input logic [15:0] a);
    devIdx = {a[15:14], a[DEV_AW-3:0]};
  endfunction

  function automatic logic [31:0] absVal(input logic [31:0] v);
    absVal = v[31] ? 32'(-v) : v;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [6:0]  ctrl_q;
  logic [1:0]  stat_q;
  logic [31:0] gear_q, ratio_q, droop_q, spdLim_q;
  logic [31:0] strkUp_q, strkLo_q, geom_q, ppRev_q;
  logic [15:0] trqSrc_q, devAddr_q, tqWord_q;
  logic [31:0] pos_q, cmdSpeed_q, cmdTravel_q;
  logic        droopErr_q, speedErr_q, strokeErr_q;
  logic [1:0]  waitCnt_q;
  logic        busMem_q;

  logic        req, ack, wr, errEvent, modeEvent;
  logic [15:0] memRdata;
  logic [31:0] readMux, travPerPulse, rollerMon;
  logic        memWe;

  assign req = read | write;
  assign ack = req && waitCnt_q == BUS_WAIT;
  assign waitrequest = req & ~ack;
  assign wr = write & ack;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      waitCnt_q <= 2'd0;
    else if (!req || ack)
      waitCnt_q <= 2'd0;
    else
      waitCnt_q <= waitCnt_q + 2'd1;
  end

  // ----------------------------------------
  // control and mode switching
  // ----------------------------------------
  logic unitBad;
  assign unitBad = writedata[CB_SCREW]
                   && writedata[CB_UNIT] != writedata[CB_REALUNIT];
  assign modeEvent = wr && address == OFS_CTRL && !ctrl_q[CB_VIRT]
                     && writedata[CB_VIRT] && unitBad;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= 7'd0;
    else if (wr && address == OFS_CTRL && byteenable[0])
    begin
      ctrl_q <= writedata[6:0];
      if (modeEvent)
        ctrl_q[CB_VIRT] <= 1'b0;
    end
  end

  // fixed backlash setting is independent of mode
  assign backlashEn = ctrl_q[CB_BACKLASH];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gear_q   <= RST_GEAR;
      ratio_q  <= RST_GEAR;
      droop_q  <= RST_DROOP;
      spdLim_q <= 32'd0;
      strkUp_q <= 32'd0;
      strkLo_q <= 32'd0;
      geom_q   <= 32'd0;
      ppRev_q  <= 32'd0;
      trqSrc_q <= 16'd0;
      devAddr_q <= 16'd0;
    end
    else if (wr)
    begin
      unique case (address)
        OFS_GEAR:    gear_q <= writedata;
        OFS_RATIO:   ratio_q <= writedata;
        OFS_DROOP:   droop_q <= writedata;
        OFS_SPDLIM:  spdLim_q <= writedata;
        OFS_STRKUP:  strkUp_q <= writedata;
        OFS_STRKLO:  strkLo_q <= writedata;
        OFS_GEOM:    geom_q <= writedata;
        OFS_PPREV:   ppRev_q <= writedata;
        OFS_TRQSRC:  trqSrc_q <= writedata[15:0];
        OFS_DEVADDR: devAddr_q <= writedata[15:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------
  // device words and torque word fetch
  // ----------------------------------------
  // bus writes into the virtual-axis block are dropped in virtual mode
  assign memWe = wr && address == OFS_DEVDATA && devValid(devAddr_q)
                 && !(ctrl_q[CB_VIRT] && devReserved(devAddr_q));

  logic busRd;
  assign busRd = read && address == OFS_DEVDATA;

  vrs_dev_mem #(.AW(DEV_AW), .DW(16)) uMem (
    .clk   (clk),
    .we    (memWe),
    .waddr (devIdx(devAddr_q)),
    .wdata (writedata[15:0]),
    .raddr (busRd ? devIdx(devAddr_q) : devIdx(trqSrc_q)),
    .rdata (memRdata)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busMem_q <= 1'b0;
    else
      busMem_q <= busRd;
  end

  // torque word refreshed on the tick only, from a torque-side read
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tqWord_q <= TRQ_DEFAULT;
    else if (opTick && !busMem_q && devValid(trqSrc_q))
      tqWord_q <= memRdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      torqueLimit <= TRQ_DEFAULT;
    else if (ctrl_q[CB_VIRT])
      torqueLimit <= ctrl_q[CB_TRQASN] ? tqWord_q : TRQ_DEFAULT;
  end

  // ----------------------------------------
  // command scaling
  // ----------------------------------------
  logic        pass;
  logic [31:0] spdGear, trvGear, spdOut, trvOut;

  function automatic logic [31:0] scaleQ(input logic [31:0] v,
                                         input logic [31:0] k);
    logic signed [64:0] p;
    p = $signed(v) * $signed({1'b0, k});
    scaleQ = p[FRAC_BITS +: 32];
  endfunction

  assign pass = !ctrl_q[CB_CLUTCH] || clutchOn;
  assign spdGear = scaleQ(driveSpeed, gear_q);
  assign trvGear = scaleQ(driveTravel, gear_q);
  assign spdOut = ctrl_q[CB_SCREW] ? spdGear
                  : scaleQ(spdGear, ratio_q);
  assign trvOut = ctrl_q[CB_SCREW] ? trvGear
                  : scaleQ(trvGear, ratio_q);

  // speeds are not clamped; limits only raise the error
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmdSpeed_q  <= 32'd0;
      cmdTravel_q <= 32'd0;
    end
    else if (opTick)
    begin
      cmdSpeed_q  <= (ctrl_q[CB_VIRT] && pass) ? spdOut : 32'd0;
      cmdTravel_q <= (ctrl_q[CB_VIRT] && pass) ? trvOut : 32'd0;
    end
  end
  assign cmdSpeed = cmdSpeed_q;
  assign cmdTravel = cmdTravel_q;

  // ----------------------------------------
  // monitors: geometry used here only
  // ----------------------------------------
  logic [63:0] monProd;
  assign monProd = 64'(absVal(cmdSpeed_q)) * 64'(geom_q) * 64'(MON_NUM);
  assign rollerMon = ppRev_q == 32'd0 ? 32'd0
                     : 32'(monProd / (64'(MON_DEN) * 64'(ppRev_q)));
  assign travPerPulse = ppRev_q == 32'd0 ? 32'd0
                        : 32'((64'(geom_q) << FRAC_BITS) / 64'(ppRev_q));

  // screw feed value is never cleared on a mode change
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pos_q <= 32'd0;
    else if (opTick && ctrl_q[CB_VIRT])
    begin
      if (ctrl_q[CB_SCREW])
        pos_q <= pos_q + cmdTravel_q;
      else
        pos_q <= rollerMon;
    end
  end

  // ----------------------------------------
  // error checks
  // ----------------------------------------
  logic strokeOn, outside;
  assign strokeOn = strkUp_q != strkLo_q;
  assign outside = $signed(pos_q) > $signed(strkUp_q)
                   || $signed(pos_q) < $signed(strkLo_q);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      droopErr_q  <= 1'b0;
      speedErr_q  <= 1'b0;
      strokeErr_q <= 1'b0;
    end
    else if (opTick)
    begin
      droopErr_q  <= absVal(deviation) > droop_q;
      speedErr_q  <= ctrl_q[CB_VIRT]
                     && absVal(cmdSpeed_q) > spdLim_q;
      strokeErr_q <= ctrl_q[CB_VIRT] && ctrl_q[CB_SCREW]
                     && strokeOn && outside;
    end
  end

  assign errEvent = droopErr_q | speedErr_q | strokeErr_q;

  // sticky; a new event wins over a write-one clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stat_q <= 2'b00;
    else
    begin
      if (wr && address == OFS_STATUS)
        stat_q <= stat_q & ~writedata[1:0];
      if (errEvent)
        stat_q[SB_ERR] <= 1'b1;
      if (modeEvent)
        stat_q[SB_MODEERR] <= 1'b1;
    end
  end
  assign axis_error_detect_flag = stat_q[SB_ERR];

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    readMux = 32'd0;
    unique case (address)
      OFS_CTRL:    readMux = {25'd0, ctrl_q};
      OFS_STATUS:  readMux = {27'd0, strokeErr_q, speedErr_q,
                              droopErr_q, stat_q};
      OFS_GEAR:    readMux = gear_q;
      OFS_RATIO:   readMux = ratio_q;
      OFS_DROOP:   readMux = droop_q;
      OFS_SPDLIM:  readMux = spdLim_q;
      OFS_STRKUP:  readMux = strkUp_q;
      OFS_STRKLO:  readMux = strkLo_q;
      OFS_TRQSRC:  readMux = {16'd0, trqSrc_q};
      OFS_GEOM:    readMux = geom_q;
      OFS_PPREV:   readMux = ppRev_q;
      OFS_DEVADDR: readMux = {16'd0, devAddr_q};
      OFS_DEVDATA: readMux = {16'd0, memRdata};
      OFS_POS:     readMux = pos_q;
      OFS_CMDSPD:  readMux = cmdSpeed_q;
      OFS_TRAVPP:  readMux = travPerPulse;
      OFS_TORQUE:  readMux = {16'd0, torqueLimit};
      default:     readMux = 32'd0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      readdata <= 32'd0;
    else if (read && waitCnt_q == BUS_WAIT - 2'd1)
      readdata <= readMux;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_switchBad;
    wr && address == OFS_CTRL && !ctrl_q[CB_VIRT] && writedata[CB_VIRT]
    && unitBad;
  endsequence

  a_droop_flag: assert property (opTick && absVal(deviation) > droop_q
    |-> ##1 droopErr_q ##1 axis_error_detect_flag)
    else $error("droop excess did not raise axis error");
  a_speed_flag: assert property (opTick && ctrl_q[CB_VIRT]
    && absVal(cmdSpeed_q) > spdLim_q |-> ##2 axis_error_detect_flag)
    else $error("speed excess did not raise axis error");
  a_no_clamp: assert property (opTick && ctrl_q[CB_VIRT] && pass
    |=> cmdSpeed_q == $past(spdOut))
    else $error("commanded speed altered");
  a_torque_dflt: assert property (ctrl_q[CB_VIRT] && !ctrl_q[CB_TRQASN]
    ##1 ctrl_q[CB_VIRT] |-> torqueLimit == TRQ_DEFAULT)
    else $error("torque default not applied");
  a_rsv_block: assert property (memWe |-> !(ctrl_q[CB_VIRT]
    && devReserved(devAddr_q)) && devValid(devAddr_q))
    else $error("reserved or invalid device word written");
  a_stroke_flag: assert property (opTick && ctrl_q[CB_VIRT]
    && ctrl_q[CB_SCREW] && strokeOn && outside |-> ##2 axis_error_detect_flag)
    else $error("stroke excess did not raise axis error");
  a_mode_err: assert property (s_switchBad
    |=> stat_q[SB_MODEERR] && !ctrl_q[CB_VIRT])
    else $error("mode switch error missing");
  a_clutch_gate: assert property (opTick && ctrl_q[CB_CLUTCH]
    && !clutchOn |=> cmdSpeed_q == 32'd0 && cmdTravel_q == 32'd0)
    else $error("motion passed with clutch off");
  a_feed_keep: assert property (ctrl_q[CB_SCREW] && !opTick
    |=> $stable(pos_q))
    else $error("feed value changed off tick");
  a_tick_only: assert property (!opTick |=> $stable(droopErr_q)
    && $stable(speedErr_q) && $stable(tqWord_q))
    else $error("check updated outside operation cycle");
endmodule

// [sim/vrs_servo_model.sv]
// servo amplifier model: follows commanded travel, reports deviation
// assumes cmdTravel from the axis; slow is raised only by the bench
`timescale 1ns/1ps
module vrs_servo_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic [31:0] cmdTravel,
  output logic      [31:0] deviation
);
  // ----------------------------------------
  // deviation counter
  // ----------------------------------------
  // prompt: motor keeps up, no droop; slow: a whole step left behind
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      deviation <= 32'h0000_0000;
    else
      deviation <= slow ? cmdTravel : 32'h0000_0000;
  end
endmodule

// [sim/tb_vrs_axis.sv]
// bench for the roller / ball-screw output axis
// assumes vrs_pkg offsets, two bus wait states, one tick per op cycle
`timescale 1ns/1ps
module tb_vrs_axis;
  import vrs_pkg::*;
  logic        clk = 0, rstn = 0, read = 0, write = 0, opTick = 0;
  logic        clutchOn = 1, slow = 0, backlashEn, axis_error_detect_flag;
  logic        waitrequest;
  logic [7:0]  address = '0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = '0, readdata, driveSpeed = '0, driveTravel = '0;
  logic [31:0] deviation, cmdSpeed, cmdTravel, q;
  logic [15:0] torqueLimit;
  int          errors = 0, comparisons = 0;
  vrs_axis dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .opTick(opTick),
    .driveSpeed(driveSpeed), .driveTravel(driveTravel),
    .clutchOn(clutchOn), .deviation(deviation), .cmdSpeed(cmdSpeed),
    .cmdTravel(cmdTravel), .torqueLimit(torqueLimit),
    .backlashEn(backlashEn),
    .axis_error_detect_flag(axis_error_detect_flag));
  vrs_servo_model servo (.clk(clk), .rstn(rstn), .slow(slow),
    .cmdTravel(cmdTravel), .deviation(deviation));
  always #5 clk = ~clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    // only the watchdog ends a wait that never finishes
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q & m, exp);
  endtask
  // one operation cycle, then room for the sticky flag to land
  task automatic tick(input logic [31:0] s, input logic [31:0] t);
    @(posedge clk);
    opTick <= 1'b1;
    driveSpeed <= s;
    driveTravel <= t;
    @(posedge clk);
    opTick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic dev(input logic [15:0] a, input logic [15:0] v);
    wr(OFS_DEVADDR, {16'h0000, a});
    wr(OFS_DEVDATA, {16'h0000, v});
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #500_000;
    errors++;
    test_done();
  end
  initial
  begin
    rst();
    chk({16'h0000, torqueLimit}, 32'd300);
    rd(OFS_DROOP, '1, RST_DROOP);
    rd(OFS_GEAR, '1, RST_GEAR);
    rd(8'hFC, '1, 32'h0000_0000);
    wr(OFS_SPDLIM, 32'h7FFF_FFFF);
    wr(OFS_GEAR, 32'h0002_0000);
    wr(OFS_CTRL, 32'h0000_0052);
    tick(32'd1000, 32'd10);
    chk(cmdSpeed, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0053);
    tick(32'd1000, 32'd10);
    chk(cmdSpeed, 32'd2000);
    chk(cmdTravel, 32'd20);
    clutchOn <= 1'b0;
    tick(32'd1000, 32'd10);
    chk(cmdSpeed, 32'h0000_0000);
    clutchOn <= 1'b1;
    wr(OFS_GEOM, 32'd2000);
    wr(OFS_PPREV, 32'd8);
    tick(32'd1000, 32'd10);
    chk(cmdSpeed, 32'd2000);
    rd(OFS_TRAVPP, '1, 32'h00FA_0000);
    wr(OFS_SPDLIM, 32'd1500);
    tick(32'd1000, 32'd10);
    chk(cmdSpeed, 32'd2000);
    chk({31'h0, axis_error_detect_flag}, 32'h1);
    rd(OFS_STATUS, 32'h0000_0009, 32'h0000_0009);
    wr(OFS_SPDLIM, 32'h7FFF_FFFF);
    wr(OFS_DROOP, 32'd100);
    slow <= 1'b1;
    repeat (3) tick(32'd1000, 32'd200);
    chk(cmdTravel, 32'd400);
    rd(OFS_STATUS, 32'h0000_0005, 32'h0000_0005);
    slow <= 1'b0;
    repeat (2) tick(32'd1000, 32'd10);
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, '1, 32'h0000_0000);
    // stroke and feed value from a clean start
    rst();
    wr(OFS_SPDLIM, 32'h7FFF_FFFF);
    wr(OFS_STRKUP, 32'd1000);
    wr(OFS_STRKLO, 32'hFFFF_FC18);
    wr(OFS_CTRL, 32'h0000_0053);
    tick(32'd100, 32'd600);
    chk({31'h0, axis_error_detect_flag}, 32'h0);
    tick(32'd100, 32'd600);
    chk(cmdTravel, 32'd600);
    // stroke check sees the feed value of the previous cycle
    repeat (2) tick(32'd0, 32'd0);
    rd(OFS_STATUS, 32'h0000_0011, 32'h0000_0011);
    rd(OFS_POS, '1, 32'd1200);
    wr(OFS_CTRL, 32'h0000_0052);
    rd(OFS_POS, '1, 32'd1200);
    chk({31'h0, backlashEn}, 32'h1);
    wr(OFS_CTRL, 32'h0000_0053);
    rd(OFS_POS, '1, 32'd1200);
    chk({31'h0, backlashEn}, 32'h1);
    wr(OFS_CTRL, 32'h0000_0052);
    wr(OFS_CTRL, 32'h0000_0057);
    rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    tick(32'd100, 32'd5);
    chk(cmdSpeed, 32'h0000_0000);
    // torque word from every area, refused writes and per-tick refresh
    rst();
    wr(OFS_CTRL, 32'h0000_0001);
    tick(32'd0, 32'd0);
    chk({16'h0000, torqueLimit}, 32'd300);
    for (int a = 0; a < 4; a++)
    begin
      dev({a[1:0], 14'd5}, 16'(100 + a * 10));
      wr(OFS_TRQSRC, {16'h0000, a[1:0], 14'd5});
      wr(OFS_CTRL, 32'h0000_0021);
      tick(32'd0, 32'd0);
      chk({16'h0000, torqueLimit}, 32'(100 + a * 10));
    end
    dev({AREA_M, 14'd0}, 16'd55);
    dev({AREA_M, 14'd8000}, 16'd77);
    wr(OFS_TRQSRC, {16'h0000, AREA_M, 14'd0});
    tick(32'd0, 32'd0);
    chk({16'h0000, torqueLimit}, 32'd55);
    dev({AREA_D, 14'd32}, 16'd66);
    dev({AREA_D, RSV_LO}, 16'd88);
    wr(OFS_TRQSRC, {16'h0000, AREA_D, 14'd32});
    tick(32'd0, 32'd0);
    chk({16'h0000, torqueLimit}, 32'd66);
    dev({AREA_D, 14'd32}, 16'd999);
    tick(32'd0, 32'd0);
    chk({16'h0000, torqueLimit}, 32'd999);
    // roller output, unclamped speed and cycle speed monitor
    wr(OFS_SPDLIM, 32'h7FFF_FFFF);
    wr(OFS_GEAR, 32'h0003_0000);
    wr(OFS_RATIO, 32'h0000_8000);
    wr(OFS_CTRL, 32'h0000_0011);
    tick(32'd1000, 32'd100);
    chk(cmdSpeed, 32'd1500);
    chk(cmdTravel, 32'd150);
    wr(OFS_SPDLIM, 32'd1000);
    tick(32'd1000, 32'd100);
    chk(cmdSpeed, 32'd1500);
    chk({31'h0, axis_error_detect_flag}, 32'h1);
    wr(OFS_SPDLIM, 32'h7FFF_FFFF);
    wr(OFS_GEAR, 32'h0001_0000);
    wr(OFS_RATIO, 32'h0001_0000);
    wr(OFS_GEOM, 32'd100);
    wr(OFS_PPREV, 32'd213);
    // monitor reads the speed commanded one cycle earlier
    repeat (2) tick(32'd1130, 32'd0);
    rd(OFS_POS, '1, 32'd1000);
    test_done();
  end
endmodule
